// file: shared/css_pkg.sv
// Package for the configuration-space export block.
// Assumes a 32-bit APB register bus and one clock domain.
package css_pkg;

  // ==========================================================
  // Bus geometry.
  localparam int CSS_DATA_W = 32;
  localparam int CSS_ADDR_W = 8;

  // ==========================================================
  // Register byte offsets.
  localparam logic [7:0] CSS_OFF_TCVC = 8'h00;
  localparam logic [7:0] CSS_OFF_BUSDEV = 8'h04;
  localparam logic [7:0] CSS_OFF_PRIM = 8'h08;
  localparam logic [7:0] CSS_OFF_DEV = 8'h0C;
  localparam logic [7:0] CSS_OFF_LINK = 8'h10;
  localparam logic [7:0] CSS_OFF_UPDCNT = 8'h14;

  // ==========================================================
  // Field layout of the traffic-class map and identity value.
  localparam int CSS_TC_NUM = 8;
  localparam int CSS_TC_W = 3;
  localparam int CSS_MAP_W = CSS_TC_NUM * CSS_TC_W;
  localparam int CSS_DEVNUM_W = 5;
  localparam int CSS_BUSNUM_W = 8;
  localparam int CSS_ID_W = CSS_BUSNUM_W + CSS_DEVNUM_W;

  // Writable bits of the map: the class 0 field stays zero.
  localparam logic [23:0] CSS_MAP_WMASK = 24'hFFFFF8;
  localparam logic [12:0] CSS_ID_WMASK = 13'h1FFF;
  localparam logic [31:0] CSS_CSR_WMASK = 32'hFFFFFFFF;

  // ==========================================================
  // Reset values.
  localparam logic [23:0] CSS_MAP_RST = 24'h000000;
  localparam logic [12:0] CSS_ID_RST = 13'h0000;
  localparam logic [31:0] CSS_CSR_RST = 32'h00000000;
  localparam logic [31:0] CSS_ZERO = 32'h00000000;

  // ==========================================================
  // Exported configuration images, carried as one bundle.
  typedef struct packed {
    logic [23:0] tcvc_map;
    logic [12:0] bus_dev;
    logic [31:0] prim_csr;
    logic [31:0] dev_csr;
    logic [31:0] link_csr;
  } css_export_s;

endpackage

// file: logic/css_word_reg.sv
// One masked storage word with a write strobe.
// Assumes a single clock and an active-low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module css_word_reg #(
  parameter int W = 32,
  parameter logic [W-1:0] WMASK = '1,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Write side.
  input wire logic wr_en,
  input wire logic [W-1:0] wdata,
  // Stored value.
  output logic [W-1:0] q
);

  // ==========================================================
  // Width check.
  if (W < 1 || W > 32) begin : g_bad_w
    $error("css_word_reg width out of range");
  end

  logic [W-1:0] q_ff;
  wire logic [W-1:0] nxt_q;

  // Masked bits take the new data, the rest keep their value.
  assign nxt_q = wr_en ? ((q_ff & ~WMASK) | (wdata & WMASK)) : q_ff;
  assign q = q_ff;

  // Storage flip-flops.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q_ff <= RST;
    end else begin
      q_ff <= nxt_q;
    end
  end

endmodule
`default_nettype wire

// file: logic/css_export.sv
// Configuration-space export block: holds the configuration images and
// drives them to the application layer.
// Assumes an APB master on clk; application logic reads the export bundle.
`timescale 1ns/1ps
`default_nettype none
module css_export
  import css_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [CSS_ADDR_W-1:0] paddr,
  input wire logic [CSS_DATA_W-1:0] pwdata,
  output logic [CSS_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Export to the application layer.
  output css_export_s cfg_out
);

  // ==========================================================
  // Bus phase decode.
  logic pready_ff;
  logic pslverr_ff;
  logic [CSS_DATA_W-1:0] prdata_ff;
  logic [CSS_DATA_W-1:0] upd_cnt_ff;

  wire logic setup_ph;
  wire logic acc_done;
  wire logic wr_acc;
  wire logic sel_tcvc;
  wire logic sel_busdev;
  wire logic sel_prim;
  wire logic sel_dev;
  wire logic sel_link;
  wire logic sel_cnt;
  wire logic sel_any;
  wire logic sel_wr_reg;

  // A transfer is answered one cycle after its setup cycle.
  assign setup_ph = psel & ~penable;
  assign acc_done = psel & penable & pready_ff;
  assign wr_acc = acc_done & pwrite;

  // Address decode.
  assign sel_tcvc = (paddr == CSS_OFF_TCVC);
  assign sel_busdev = (paddr == CSS_OFF_BUSDEV);
  assign sel_prim = (paddr == CSS_OFF_PRIM);
  assign sel_dev = (paddr == CSS_OFF_DEV);
  assign sel_link = (paddr == CSS_OFF_LINK);
  assign sel_cnt = (paddr == CSS_OFF_UPDCNT);
  assign sel_wr_reg = sel_tcvc | sel_busdev | sel_prim | sel_dev | sel_link;
  assign sel_any = sel_wr_reg | sel_cnt;

  // ==========================================================
  // Configuration images.
  wire logic [CSS_MAP_W-1:0] map_q;
  wire logic [CSS_ID_W-1:0] id_q;
  wire logic [CSS_DATA_W-1:0] prim_q;
  wire logic [CSS_DATA_W-1:0] dev_q;
  wire logic [CSS_DATA_W-1:0] link_q;

  // Class map; the class 0 field is never writable.
  css_word_reg #(.W(CSS_MAP_W), .WMASK(CSS_MAP_WMASK),
    .RST(CSS_MAP_RST)) u_map (
    .clk(clk), .rst_n(rst_n), .wr_en(wr_acc & sel_tcvc),
    .wdata(pwdata[CSS_MAP_W-1:0]), .q(map_q));

  // Bus number over device number.
  css_word_reg #(.W(CSS_ID_W), .WMASK(CSS_ID_WMASK),
    .RST(CSS_ID_RST)) u_id (
    .clk(clk), .rst_n(rst_n), .wr_en(wr_acc & sel_busdev),
    .wdata(pwdata[CSS_ID_W-1:0]), .q(id_q));

  // Primary command and status image.
  css_word_reg #(.W(CSS_DATA_W), .WMASK(CSS_CSR_WMASK),
    .RST(CSS_CSR_RST)) u_prim (
    .clk(clk), .rst_n(rst_n), .wr_en(wr_acc & sel_prim),
    .wdata(pwdata), .q(prim_q));

  // Device control and status image.
  css_word_reg #(.W(CSS_DATA_W), .WMASK(CSS_CSR_WMASK),
    .RST(CSS_CSR_RST)) u_dev (
    .clk(clk), .rst_n(rst_n), .wr_en(wr_acc & sel_dev),
    .wdata(pwdata), .q(dev_q));

  // Link control and status image.
  css_word_reg #(.W(CSS_DATA_W), .WMASK(CSS_CSR_WMASK),
    .RST(CSS_CSR_RST)) u_link (
    .clk(clk), .rst_n(rst_n), .wr_en(wr_acc & sel_link),
    .wdata(pwdata), .q(link_q));

  // The export bundle is the storage itself, so it never lags it.
  // One assignment in field order keeps the bundle to a single driver.
  assign cfg_out = {map_q, id_q, prim_q, dev_q, link_q};

  // ==========================================================
  // Read data selection; unmapped addresses read as zero.
  wire logic [CSS_DATA_W-1:0] rd_word;
  wire logic [CSS_DATA_W-1:0] nxt_prdata;
  wire logic nxt_pready;
  wire logic nxt_pslverr;
  wire logic [CSS_DATA_W-1:0] nxt_upd_cnt;

  assign rd_word =
    sel_tcvc ? {{(CSS_DATA_W-CSS_MAP_W){1'b0}}, map_q} :
    sel_busdev ? {{(CSS_DATA_W-CSS_ID_W){1'b0}}, id_q} :
    sel_prim ? prim_q :
    sel_dev ? dev_q :
    sel_link ? link_q :
    sel_cnt ? upd_cnt_ff : CSS_ZERO;

  assign nxt_pready = setup_ph;
  assign nxt_prdata = setup_ph ? rd_word : prdata_ff;
  assign nxt_pslverr = setup_ph & ~sel_any;
  assign nxt_upd_cnt = (wr_acc & sel_wr_reg) ? upd_cnt_ff + 32'h00000001
                                             : upd_cnt_ff;

  // Bus answer flip-flops, loaded in the setup cycle.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= CSS_ZERO;
    end else begin
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      prdata_ff <= nxt_prdata;
    end
  end

  // Count of accepted image writes, readable as block state.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      upd_cnt_ff <= CSS_ZERO;
    end else begin
      upd_cnt_ff <= nxt_upd_cnt;
    end
  end

  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign prdata = prdata_ff;

  // ==========================================================
  // Assertions.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_wr(logic [7:0] off);
    psel && penable && pready && pwrite && paddr == off;
  endsequence

  // Outside writes, no exported image moves.
  property p_hold;
    !(psel && penable && pready && pwrite) |=> $stable(cfg_out);
  endproperty
  a_hold: assert property (p_hold)
    else $error("export changed without a write");

  property p_map_write;
    s_wr(CSS_OFF_TCVC) |=> cfg_out.tcvc_map[CSS_MAP_W-1:CSS_TC_W] ==
      $past(pwdata[CSS_MAP_W-1:CSS_TC_W]);
  endproperty
  a_map_write: assert property (p_map_write)
    else $error("class map did not take written fields");

  property p_tc0_zero;
    cfg_out.tcvc_map[CSS_TC_W-1:0] == 3'h0;
  endproperty
  a_tc0_zero: assert property (p_tc0_zero)
    else $error("class 0 field is not zero");

  property p_tc7_top;
    s_wr(CSS_OFF_TCVC) ##1 (!(psel && penable && pwrite))[*2] |->
      cfg_out.tcvc_map[23:21] == $past(pwdata[23:21], 3);
  endproperty
  a_tc7_top: assert property (p_tc7_top)
    else $error("class 7 field not held in top bits");

  property p_tc24;
    s_wr(CSS_OFF_TCVC) |=> cfg_out.tcvc_map[8:6] == $past(pwdata[8:6]) &&
      cfg_out.tcvc_map[14:12] == $past(pwdata[14:12]);
  endproperty
  a_tc24: assert property (p_tc24)
    else $error("class 2 or 4 field misplaced");

  property p_busdev;
    s_wr(CSS_OFF_BUSDEV) |=> cfg_out.bus_dev ==
      {$past(pwdata[12:5]), $past(pwdata[4:0])};
  endproperty
  a_busdev: assert property (p_busdev)
    else $error("bus and device number mismatch");

  property p_prim;
    s_wr(CSS_OFF_PRIM) |=> cfg_out.prim_csr == $past(pwdata);
  endproperty
  a_prim: assert property (p_prim)
    else $error("primary image not updated");

  property p_dev;
    s_wr(CSS_OFF_DEV) |=> cfg_out.dev_csr == $past(pwdata);
  endproperty
  a_dev: assert property (p_dev)
    else $error("device image not updated");

  property p_link;
    s_wr(CSS_OFF_LINK) |=> cfg_out.link_csr == $past(pwdata);
  endproperty
  a_link: assert property (p_link)
    else $error("link image not updated");

  property p_answer;
    psel && !penable |=> pready ##1 !pready;
  endproperty
  a_answer: assert property (p_answer)
    else $error("answer not one cycle after setup");

  c_map_wr: cover property (s_wr(CSS_OFF_TCVC));
  c_link_rd: cover property (psel && penable && pready && !pwrite &&
    paddr == CSS_OFF_LINK);
  c_err: cover property (pready && pslverr);

endmodule
`default_nettype wire

// file: verification/css_app_model.sv
// Application-side model that builds packet channel and transaction ID.
// Assumes it reads the export bundle of the configuration block.
`timescale 1ns/1ps
`default_nettype none
module css_app_model
  import css_pkg::*;
(
  // Exported configuration.
  input wire css_export_s cfg,
  // Packet class in, routing out.
  input wire logic [2:0] tc,
  output logic [2:0] vc,
  output logic [15:0] txn_id
);
  // ==========================================================
  // Channel lookup by class and ID build with function zero.
  assign vc = cfg.tcvc_map[3*int'(tc) +: 3];
  assign txn_id = {cfg.bus_dev, 3'h0};
endmodule
`default_nettype wire

// file: verification/css_export_bench.sv
// Self-checking bench for the configuration export block.
// Assumes the APB timing of the block and the application model.
`timescale 1ns/1ps
`default_nettype none
module css_export_bench
  import css_pkg::*;
;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  css_export_s cfg_out;
  logic [2:0] tc, vc;
  logic [15:0] txn_id;
  int errors, compares, cycles;

  css_export css_export_inst (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cfg_out(cfg_out));
  css_app_model css_app_model_inst (.cfg(cfg_out), .tc(tc), .vc(vc),
    .txn_id(txn_id));

  // ==========================================================
  // Clock and hang guard.
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      errors = errors + 1;
      wrap_up();
    end
  end

  // ==========================================================
  // Compare, bus cycle and verdict tasks.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares = compares + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Hold the request until ready is seen at an edge.
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic ee);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
    chk({31'h0, e}, {31'h0, ee});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x,
      input logic ee);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q, x);
    chk({31'h0, e}, {31'h0, ee});
  endtask
  task automatic wrap_up();
    if (errors == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ==========================================================
  // Main sequence.
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    tc = 3'h0;
    errors = 0;
    compares = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk({31'h0, |cfg_out}, 32'h0);
    for (int i = 0; i < 6; i++) rd(8'(4 * i), 32'h0, 1'b0);
    // Class 0 field cannot be written.
    wr(CSS_OFF_TCVC, 32'hFFFFFFFF, 1'b0);
    @(negedge clk);
    chk(32'(cfg_out.tcvc_map), 32'h00FFFFF8);
    rd(CSS_OFF_TCVC, 32'h00FFFFF8, 1'b0);
    // Each class n maps to channel n, read back through the model.
    wr(CSS_OFF_TCVC, 32'h00FAC688, 1'b0);
    @(negedge clk);
    chk(32'(cfg_out.tcvc_map), 32'h00FAC688);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk) tc <= 3'(i);
      @(negedge clk) chk(32'(vc), 32'(i));
    end
    // Identity: bus 5E, device 0D.
    wr(CSS_OFF_BUSDEV, 32'hFFFFABCD, 1'b0);
    @(negedge clk);
    chk(32'(cfg_out.bus_dev[12:5]), 32'h5E);
    chk(32'(cfg_out.bus_dev[4:0]), 32'h0D);
    chk(32'(txn_id), 32'h5E68);
    rd(CSS_OFF_BUSDEV, 32'h00000BCD, 1'b0);
    // Control and status images with all 32 bits in play.
    wr(CSS_OFF_PRIM, 32'h8001FFFE, 1'b0);
    wr(CSS_OFF_DEV, 32'h7FFE0001, 1'b0);
    wr(CSS_OFF_LINK, 32'hC3A5965A, 1'b0);
    @(negedge clk);
    chk(cfg_out.prim_csr, 32'h8001FFFE);
    chk(cfg_out.dev_csr, 32'h7FFE0001);
    chk(cfg_out.link_csr, 32'hC3A5965A);
    rd(CSS_OFF_PRIM, 32'h8001FFFE, 1'b0);
    rd(CSS_OFF_DEV, 32'h7FFE0001, 1'b0);
    rd(CSS_OFF_LINK, 32'hC3A5965A, 1'b0);
    // Unmapped place and read-only counter leave the images alone.
    wr(8'h18, 32'hFFFFFFFF, 1'b1);
    rd(8'h18, 32'h0, 1'b1);
    wr(CSS_OFF_UPDCNT, 32'h000000FF, 1'b0);
    rd(CSS_OFF_UPDCNT, 32'h00000006, 1'b0);
    chk(cfg_out.link_csr, 32'hC3A5965A);
    wrap_up();
  end
endmodule
`default_nettype wire
